//--- shared/host_link_pkg.sv
// Constants for the host-side wake/ready SPI handshake controller.
// Assumes a 50 MHz system clock; all timing counts derive from it.
package host_link_pkg;
   localparam int SYS_CLK_HZ = 50_000_000;
   // SPI link clock: typical and maximum rate
   localparam int SPI_TYP_HZ = 32_768;
   localparam int SPI_MAX_HZ = 1_625_000;
   // Least divider that keeps the serial clock at or under the maximum
   localparam int SPI_MIN_HALF = (SYS_CLK_HZ + 2 * SPI_MAX_HZ - 1) / (2 * SPI_MAX_HZ);
   // Default half period gives the typical rate
   localparam int SPI_TYP_HALF = SYS_CLK_HZ / (2 * SPI_TYP_HZ);
   // Least gap between raising and lowering the request line
   localparam int REARM_GAP_US = 3000;
   localparam int REARM_GAP_CYC = (REARM_GAP_US * (SYS_CLK_HZ / 1_000_000));
   // Time to wait for the ready answer before a retry
   localparam int READY_WAIT_US = 5000;
   localparam int READY_WAIT_CYC = (READY_WAIT_US * (SYS_CLK_HZ / 1_000_000));
   // Filler byte for clocking in device data
   localparam logic [7:0] FILL_BYTE = 8'hFF;
   localparam int WORD_BITS = 8;
   localparam logic [3:0] BIT_LAST = 4'h7;
   // UART host port fixed settings
   localparam int UART_BAUD = 57600;
   localparam int UART_DATA_BITS = 8;
   localparam int UART_STOP_BITS = 1;
endpackage

//--- design/host_link_ctrl.sv
// Host-side controller for the wake/ready handshake around an SPI slave.
// Assumes the device pins are asynchronous; the serial clock is made here.
//
// What the link requires of this block and of the device
// R01: Idle: request, select high; surge input expected low, device request high.
// R02: Request line driven low before any transfer starts.
// R03: Device answers the request by pulling its request line low when ready.
// R04: Chip select held low for the whole transfer.
// R05: Request raised at transfer end; device then releases its request line.
// R06: Filler bytes sent by this host are always FF.
// R07: Device-initiated request answered by lowering request, then transferring.
// R08: Device shifts a filler FF before its packet in its own transfers.
// R09: Request raised after a full packet is received.
// R10: Device keeps its request line low when another packet is queued.
// R11: Device request still low after closing: request again and transfer.
// R12: Device ignores requests while going to deep sleep after release.
// R13: At least 3 ms between raising request and lowering it again.
// R14: No ready answer: raise request, then lower it again to retry.
// R15: Surge indicator high during radio activity or calibration.
// R16: Surge indicator high on timer wake from deep sleep.
// R17: Surge indicator stays low on host wake or power-down recovery.
// R18: Surge indicator leads the current rise by slots or about 1 ms.
// R19: Surge indicator falls when radio work ends or deep sleep begins.
// R20: SPI mode 3, 8-bit words, active-low select.
// R21: Serial clock typically 32.768 kHz and never above 1.625 MHz.
// R22: UART host port: 57600 baud, 8 data bits, no parity, one stop.
// R23: Asynchronous device lines are synchronised before use.
`timescale 1ns/100ps
`default_nettype none
module host_link_ctrl
   import host_link_pkg::*;
#(
   parameter int HALF_DIV = SPI_TYP_HALF,
   parameter int REARM_CYC = REARM_GAP_CYC,
   parameter int WAIT_CYC = READY_WAIT_CYC
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // User command side
   input wire logic xfer_start,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   input wire logic xfer_last,
   output logic tx_ready,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   output logic busy,
   output logic device_pending,
   output logic surge_active,
   // Device pins
   output logic host_wake_n,
   input wire logic device_req_n,
   input wire logic current_surge_indicator,
   output logic spi_select_n,
   output logic spi_clk,
   output logic spi_mosi,
   input wire logic spi_miso
);
   //----------------------------------------
   // Elaboration checks
   //----------------------------------------
   initial
   begin
      // Either host port moves whole bytes of the same width
      if (HALF_DIV < SPI_MIN_HALF || HALF_DIV > 65535 || REARM_CYC < 1 || WAIT_CYC < 1
         || UART_DATA_BITS != WORD_BITS) // R22
      begin
         $error("host_link_ctrl: bad parameter");
      end
   end

   //----------------------------------------
   // Input synchronisers
   //----------------------------------------
   logic [1:0] irq_s_r, surge_s_r, miso_s_r;
   // Two flops per asynchronous input
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         irq_s_r <= 2'h3;
         surge_s_r <= 2'h0;
         miso_s_r <= 2'h3;
      end
      else
      begin
         irq_s_r <= {irq_s_r[0], device_req_n}; // R23
         surge_s_r <= {surge_s_r[0], current_surge_indicator}; // R23
         miso_s_r <= {miso_s_r[0], spi_miso};
      end
   end
   wire logic dev_ready = !irq_s_r[1];

   //----------------------------------------
   // Handshake and shifter
   //----------------------------------------
   typedef enum logic [2:0] {S_IDLE, S_WAKE, S_SEL, S_SHIFT, S_DESEL, S_GAP} state_t;
   state_t st_r, st_nxt;
   logic wake_r, wake_nxt, sel_r, sel_nxt, sck_r, sck_nxt, mosi_r, mosi_nxt;
   logic [15:0] div_r, div_nxt;
   logic [31:0] tmr_r, tmr_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic [7:0] sh_r, sh_nxt, rx_r, rx_nxt;
   logic rxv_r, rxv_nxt, txr_r, txr_nxt, last_r, last_nxt, retry_r, retry_nxt;

   // Next-state logic
   always_comb
   begin
      st_nxt = st_r;
      wake_nxt = wake_r;
      sel_nxt = sel_r;
      sck_nxt = sck_r;
      mosi_nxt = mosi_r;
      div_nxt = div_r;
      tmr_nxt = tmr_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      rx_nxt = rx_r;
      rxv_nxt = 1'b0;
      txr_nxt = 1'b0;
      last_nxt = last_r;
      retry_nxt = 1'b0;
      unique case (st_r)
         S_IDLE:
         begin
            // Start on a user command or on a device request
            if (xfer_start || dev_ready) // R07 R11
            begin
               wake_nxt = 1'b0; // R02
               tmr_nxt = 32'h0;
               st_nxt = S_WAKE;
            end
         end
         S_WAKE:
         begin
            tmr_nxt = tmr_r + 32'h1;
            if (dev_ready) // R03
            begin
               sel_nxt = 1'b0; // R04
               div_nxt = 16'h0;
               st_nxt = S_SEL;
            end
            else if (tmr_r >= 32'(WAIT_CYC))
            begin
               wake_nxt = 1'b1; // R14
               retry_nxt = 1'b1;
               tmr_nxt = 32'h0;
               st_nxt = S_GAP;
            end
         end
         S_SEL:
         begin
            // Wait out the select setup, then load once: one tx_ready pulse per word taken from tx_byte
            div_nxt = div_r + 16'h1;
            if (div_r >= 16'(HALF_DIV - 1))
            begin
               sh_nxt = tx_valid ? tx_byte : FILL_BYTE; // R06 R08
               last_nxt = !tx_valid || xfer_last;
               txr_nxt = tx_valid;
               bit_nxt = 3'h0;
               div_nxt = 16'h0;
               mosi_nxt = tx_valid ? tx_byte[7] : FILL_BYTE[7];
               st_nxt = S_SHIFT;
            end
         end
         S_SHIFT:
         begin
            // Mode 3: clock idles high, drive on fall, sample on rise
            div_nxt = div_r + 16'h1;
            if (div_r >= 16'(HALF_DIV - 1)) // R21
            begin
               div_nxt = 16'h0;
               sck_nxt = !sck_r; // R20
               if (!sck_r)
               begin
                  sh_nxt = {sh_r[6:0], miso_s_r[1]};
                  if (bit_r == BIT_LAST[2:0])
                  begin
                     rx_nxt = {sh_r[6:0], miso_s_r[1]};
                     rxv_nxt = 1'b1;
                     st_nxt = S_DESEL;
                  end
                  else
                  begin
                     bit_nxt = bit_r + 3'h1;
                  end
               end
               else
               begin
                  mosi_nxt = sh_r[7];
               end
            end
         end
         S_DESEL:
         begin
            div_nxt = div_r + 16'h1;
            if (div_r >= 16'(HALF_DIV - 1))
            begin
               div_nxt = 16'h0;
               if (last_r)
               begin
                  sel_nxt = 1'b1; // R04
                  wake_nxt = 1'b1; // R05 R09
                  tmr_nxt = 32'h0;
                  st_nxt = S_GAP;
               end
               else
               begin
                  st_nxt = S_SEL;
               end
            end
         end
         S_GAP:
         begin
            // Hold request high for the re-arm gap
            tmr_nxt = tmr_r + 32'h1;
            if (tmr_r >= 32'(REARM_CYC - 1)) // R13 R12
            begin
               st_nxt = S_IDLE;
            end
         end
      endcase
   end

   // State registers
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         st_r <= S_IDLE;
         wake_r <= 1'b1; // R01
         sel_r <= 1'b1; // R01
         sck_r <= 1'b1;
         mosi_r <= 1'b1;
         div_r <= 16'h0;
         tmr_r <= 32'h0;
         bit_r <= 3'h0;
         sh_r <= 8'hFF;
         rx_r <= 8'h00;
         rxv_r <= 1'b0;
         txr_r <= 1'b0;
         last_r <= 1'b0;
         retry_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         wake_r <= wake_nxt;
         sel_r <= sel_nxt;
         sck_r <= sck_nxt;
         mosi_r <= mosi_nxt;
         div_r <= div_nxt;
         tmr_r <= tmr_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         rx_r <= rx_nxt;
         rxv_r <= rxv_nxt;
         txr_r <= txr_nxt;
         last_r <= last_nxt;
         retry_r <= retry_nxt;
      end
   end

   //----------------------------------------
   // Status outputs
   //----------------------------------------
   logic busy_r, pend_r;
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         busy_r <= 1'b0;
         pend_r <= 1'b0;
      end
      else
      begin
         busy_r <= (st_nxt != S_IDLE);
         pend_r <= dev_ready;
      end
   end

   assign host_wake_n = wake_r;
   assign spi_select_n = sel_r;
   assign spi_clk = sck_r;
   assign spi_mosi = mosi_r;
   assign rx_byte = rx_r;
   assign rx_valid = rxv_r;
   assign tx_ready = txr_r;
   assign busy = busy_r;
   assign device_pending = pend_r;
   assign surge_active = surge_s_r[1]; // R15 R16 R19

   //----------------------------------------
   // Checks
   //----------------------------------------
   logic [31:0] gap_cnt_r;
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         gap_cnt_r <= 32'hFFFF_FFFF;
      end
      else if (!wake_r && wake_nxt)
      begin
         gap_cnt_r <= 32'h0;
      end
      else if (gap_cnt_r != 32'hFFFF_FFFF)
      begin
         gap_cnt_r <= gap_cnt_r + 32'h1;
      end
   end

   chk_wake_before_sel: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $fell(sel_r) |-> !wake_r) else $error("select fell without request"); // R02
   chk_sel_needs_ready: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $fell(sel_r) |-> $past(dev_ready)) else $error("select before ready"); // R03
   chk_sel_during_clk: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $changed(sck_r) |-> !sel_r) else $error("clock moved while deselected"); // R04
   chk_idle_clk_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
      sel_r |-> sck_r) else $error("clock not idle high"); // R20
   chk_rearm_gap: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $fell(wake_r) |-> gap_cnt_r >= 32'(REARM_CYC) - 32'h1) else $error("gap short"); // R13
   chk_release_on_end: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(sel_r) |-> wake_r) else $error("request held after end"); // R05
   chk_retry_raise: assert property (@(posedge sys_clk) disable iff (!rst_b)
      retry_r |-> wake_r && sel_r) else $error("retry without release"); // R14
   chk_clk_rate: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $changed(sck_r) |=> !$changed(sck_r)) else $error("clock too fast"); // R21
   cov_host_xfer: cover property (@(posedge sys_clk) disable iff (!rst_b) rxv_r && last_r);
   cov_retry: cover property (@(posedge sys_clk) disable iff (!rst_b) retry_r);
   cov_dev_req: cover property (@(posedge sys_clk) disable iff (!rst_b)
      st_r == S_IDLE && dev_ready && !xfer_start);
endmodule
`default_nettype wire

//--- sim/dev_model.sv
// Behavioural device at the far end of the wake/ready SPI link.
// Assumes mode 3 framing from the host; delays in ns, scaled down.
`timescale 1ns/100ps
`default_nettype none
module dev_model
#(
   parameter int READY_NS = 300,
   parameter int SLEEP_NS = 500
)
(
   // Handshake pins
   input wire logic host_wake_n,
   output logic device_req_n,
   output logic current_surge_indicator,
   // Serial pins
   input wire logic spi_select_n,
   input wire logic spi_clk,
   input wire logic spi_mosi,
   output logic spi_miso,
   // Bench control
   input wire logic ignore,
   input wire logic surge_in
);
   logic [7:0] out_q[$];
   logic [7:0] rx_q[$];
   logic [7:0] sh;
   logic [7:0] rsh;
   logic need;
   logic dozing;
   int nb;
   // Idle levels
   initial
   begin
      device_req_n = 1'b1;
      spi_miso = 1'b1;
      dozing = 1'b0;
      need = 1'b0;
      nb = 0;
   end
   // Surge indicator follows the bench's view of radio load
   assign current_surge_indicator = surge_in;
   // Answer a host request once ready, unless dozing off or mute
   always @(negedge host_wake_n)
   begin
      if (!ignore && !dozing)
      begin
         #(READY_NS);
         if (!host_wake_n)
            device_req_n = 1'b0;
      end
   end
   // Release on the rising request unless more packets wait
   always @(posedge host_wake_n)
   begin
      if (out_q.size() == 0 && !device_req_n)
      begin
         device_req_n = 1'b1;
         dozing = 1'b1;
         #(SLEEP_NS);
         dozing = 1'b0;
      end
   end
   // Queue one packet behind a filler and ask for service
   task automatic push(input logic [7:0] b);
      out_q.push_back(8'hFF);
      out_q.push_back(b);
      device_req_n = 1'b0;
   endtask
   // A new frame wants a fresh byte
   always @(negedge spi_select_n)
   begin
      need = 1'b1;
      nb = 0;
   end
   // Mode 3: drive on the falling clock, loading lazily
   always @(negedge spi_clk)
   begin
      if (!spi_select_n)
      begin
         if (need)
            sh = (out_q.size() != 0) ? out_q.pop_front() : 8'hFF;
         need = 1'b0;
         spi_miso = sh[7];
         sh = {sh[6:0], 1'b1};
      end
   end
   // Sample on the rising clock, MSB first
   always @(posedge spi_clk)
   begin
      if (!spi_select_n)
      begin
         rsh = {rsh[6:0], spi_mosi};
         nb = nb + 1;
         if (nb == 8)
         begin
            rx_q.push_back(rsh);
            nb = 0;
            need = 1'b1;
         end
      end
   end
   // A released data line shows the inverse of its last bit
   always @(posedge spi_select_n)
      spi_miso = ~spi_miso;
endmodule
`default_nettype wire

//--- sim/host_link_ctrl_tb.sv
// Self-checking bench for the host wake/ready SPI controller.
// Assumes dev_model on the far side and shortened counts.
`timescale 1ns/100ps
`default_nettype none
module host_link_ctrl_tb;
   import host_link_pkg::*;
   localparam int HD = 16;
   localparam int RC = 50;
   localparam int WC = 200;
   logic sys_clk, rst_b, xfer_start, tx_valid, xfer_last, ignore, surge_in;
   logic [7:0] tx_byte, rx_byte;
   logic tx_ready, rx_valid, busy, device_pending, surge_active;
   logic host_wake_n, device_req_n, current_surge_indicator;
   logic spi_select_n, spi_clk, spi_mosi, spi_miso;
   logic [31:0] seed;
   logic sck_q;
   logic [7:0] w[$];
   logic [7:0] e[$];
   int bad_count, checks_done, rise_gap, n_falls, f0, sck_hold;
   // ----------------------------------------
   // Instances
   // ----------------------------------------
   host_link_ctrl #(.HALF_DIV(HD), .REARM_CYC(RC), .WAIT_CYC(WC)) u_host_link_ctrl (
      .sys_clk(sys_clk), .rst_b(rst_b), .xfer_start(xfer_start), .tx_byte(tx_byte),
      .tx_valid(tx_valid), .xfer_last(xfer_last), .tx_ready(tx_ready), .rx_byte(rx_byte),
      .rx_valid(rx_valid), .busy(busy), .device_pending(device_pending),
      .surge_active(surge_active), .host_wake_n(host_wake_n), .device_req_n(device_req_n),
      .current_surge_indicator(current_surge_indicator), .spi_select_n(spi_select_n),
      .spi_clk(spi_clk), .spi_mosi(spi_mosi), .spi_miso(spi_miso));
   dev_model u_dev_model (
      .host_wake_n(host_wake_n), .device_req_n(device_req_n),
      .current_surge_indicator(current_surge_indicator), .spi_select_n(spi_select_n),
      .spi_clk(spi_clk), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .ignore(ignore),
      .surge_in(surge_in));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Free-running 50 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Repeatable pseudo-random step
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // Byte compare
   task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
      checks_done++;
      if (g !== x)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, x, g);
      end
   endtask
   // Verdict and end of run
   task automatic close_out();
      $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // One transfer: offer words, compare returned bytes, then what the device saw
   task automatic run(input logic [7:0] wq[$], input logic [7:0] eq[$], input logic st);
      int i, k, n;
      i = 0;
      k = 0;
      n = 0;
      tx_byte <= wq[0];
      tx_valid <= 1'b1;
      xfer_last <= (wq.size() == 1);
      xfer_start <= st;
      while (k < eq.size() && n < 20000)
      begin
         @(posedge sys_clk);
         n++;
         if (tx_ready === 1'b1)
         begin
            xfer_start <= 1'b0;
            i++;
            if (i < wq.size())
               tx_byte <= wq[i];
            xfer_last <= (i >= wq.size() - 1);
         end
         if (rx_valid === 1'b1)
         begin
            chk("rx_byte", eq[k], rx_byte);
            k++;
         end
      end
      while (busy !== 1'b0 && n < 40000)
      begin
         @(posedge sys_clk);
         n++;
      end
      foreach (wq[j])
         chk("mosi_byte", wq[j], u_dev_model.rx_q.pop_front());
   endtask
   // Gap between raise and next fall of the request line
   always @(posedge sys_clk)
   begin
      rise_gap <= !rst_b ? 100000 : (host_wake_n ? rise_gap + 1 : 0);
      if (rst_b && host_wake_n === 1'b0 && rise_gap != 0)
      begin
         n_falls <= n_falls + 1;
         if (rise_gap < 10000)
            chk("rearm_gap", 8'h01, {7'h00, rise_gap >= RC});
      end
   end
   // Cycles between serial clock edges never below the fastest legal half period
   always @(posedge sys_clk)
   begin
      sck_q <= spi_clk;
      sck_hold <= (spi_clk !== sck_q) ? 1 : sck_hold + 1;
      if (rst_b && spi_clk !== sck_q)
         chk("sck_half", 8'h01, {7'h00, sck_hold >= SPI_MIN_HALF});
   end
   // Watchdog
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      bad_count++;
      close_out();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {rst_b, xfer_start, tx_valid, xfer_last, ignore, surge_in} = 6'h00;
      tx_byte = 8'hFF;
      bad_count = 0;
      checks_done = 0;
      n_falls = 0;
      rise_gap = 0;
      sck_hold = 100000;
      sck_q = 1'b1;
      seed = 32'h0000002C;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      chk("idle_pins", 8'h1E, {3'h0, host_wake_n, spi_select_n, spi_clk, device_req_n,
         surge_active});
      run('{8'h00, 8'h80}, '{8'hFF, 8'hFF}, 1'b1);
      for (int r = 0; r < 4; r++)
      begin
         w.delete();
         e.delete();
         seed = xs(seed);
         for (int j = 0; j <= seed[1:0] % 3; j++)
         begin
            seed = xs(seed);
            w.push_back(seed[7:0]);
            e.push_back(8'hFF);
         end
         run(w, e, 1'b1);
      end
      seed = xs(seed);
      u_dev_model.push(seed[7:0]);
      repeat (5) @(posedge sys_clk);
      chk("device_pending", 8'h01, {7'h00, device_pending});
      run('{8'hFF, 8'hFF}, '{8'hFF, seed[7:0]}, 1'b0);
      chk("req_released", 8'h01, {7'h00, device_req_n});
      u_dev_model.push(8'hA5);
      u_dev_model.push(8'h3C);
      run('{8'hFF, 8'hFF}, '{8'hFF, 8'hA5}, 1'b0);
      run('{8'hFF, 8'hFF}, '{8'hFF, 8'h3C}, 1'b0);
      f0 = n_falls;
      ignore <= 1'b1;
      fork
         begin
            repeat (WC + 20) @(posedge sys_clk);
            ignore <= 1'b0;
         end
         run('{8'h5A}, '{8'hFF}, 1'b1);
      join
      chk("retry_falls", 8'h01, {7'h00, n_falls - f0 >= 2});
      surge_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      chk("surge_high", 8'h01, {7'h00, surge_active});
      surge_in <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk("surge_low", 8'h00, {7'h00, surge_active});
      close_out();
   end
endmodule
`default_nettype wire
